/* File: adc_post_top.sv */
// Two-channel decimation, DC-block filter, phase calibration and result buffer
//
// What this block does
// - Sinc3 decimator with ratio N equal to OSR for OSR up to 1024.
// - From OSR 2048, sinc3 runs at 1024 followed by sinc1 of 2 to 16.
// - Optional high-pass removes offset and low-frequency content per channel.
// - Nonzero cutoff code enables high-pass on channels whose bypass bit is clear; zero bypasses it on all channels.
// - Per-channel bypass bit skips the high-pass while the cutoff code is nonzero.
// - Coefficient is two to the minus (code plus one), 1/4 down to 1/65536.
// - Two-bit per-channel select picks normal input, shorted input or shared positive/negative test signal.
// - Phase setting is 10-bit two's complement, in modulator cycles from zero phase.
// - Phase range is -OSR/2 to OSR/2-1, or -512 to 511 above OSR 1024.
// - Out-of-range phase saturates to the nearest limit, never wraps.
// - Each result uses OSR modulator samples; zero phases give aligned windows.
// - Nonzero phase shifts that channel's window by the programmed cycles.
// - Data-ready strobe timing follows the channels' phase settings.
`timescale 1ns/1ps
`default_nettype none
`include "adc_post_map.svh"
module adc_post_top
#(
	parameter int NUM_CHANNELS = 2
)
(
	input  wire logic                               ref_clk_in,
	input  wire logic                               rst_n_in,
	input  wire logic                               mod_valid_in,
	input  wire logic [NUM_CHANNELS-1:0]            mod_bit_in,
	input  wire logic [`OSR_CODE_W-1:0]             osr_code_in,
	input  wire logic [`HP_CODE_W-1:0]              highpass_cutoff_code_in,
	input  wire adc_post_pkg::chan_cfg_t [NUM_CHANNELS-1:0] channel_setup_in,
	input  wire logic                               result_ready_in,
	output var  adc_post_pkg::result_t              result_data_out,
	output var  logic                               result_valid_out,
	output var  logic                               result_ready_strobe_out,
	output var  logic                               result_overrun_out,
	output var  adc_post_pkg::input_select_t [NUM_CHANNELS-1:0] channel_input_select_out
);
	import adc_post_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [`WIN_W-1:0]                            gcnt;
		logic [NUM_CHANNELS-1:0]                      have;
		logic [NUM_CHANNELS-1:0][`RESULT_W-1:0]       lat;
		result_t [1:0]                                slot;
		logic [1:0]                                   vld;
		logic                                         strobe;
		logic                                         overrun;
		input_select_t [NUM_CHANNELS-1:0]             sel;
	} top_state_t;

	top_state_t st;
	top_state_t next_st;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic signed [10:0] clip_phase(input logic signed [`PHASE_W-1:0] p,
		input logic [4:0] l3);
		logic signed [10:0] half;
		logic signed [10:0] p11;
		half = 11'sh001 <<< (l3 - 5'h01);
		p11 = 11'(p);
		if (p11 < -half)
			clip_phase = -half;
		else if (p11 > half - 11'sh001)
			clip_phase = half - 11'sh001;
		else
			clip_phase = p11;
	endfunction

	function automatic logic [`WIN_W-1:0] low_mask(input logic [4:0] l);
		low_mask = `WIN_W'((15'h0001 << l) - 15'h0001);
	endfunction

	// ------------------------------------------------------------
	// OSR decode
	// ------------------------------------------------------------
	logic [`OSR_CODE_W-1:0] osr_code;
	logic [4:0]             l_all;
	logic [4:0]             l3;
	logic [4:0]             l1;
	logic [6:0]             norm_shift;
	logic [`WIN_W-1:0]      mask_all;
	logic [`WIN_W-1:0]      mask3;
	logic [4:0]             hp_shift;

	always_comb
	begin
		osr_code = (osr_code_in > `OSR_CODE_MAX) ? `OSR_CODE_MAX : osr_code_in;
		l_all = `OSR_LOG2_BASE + 5'(osr_code);
		l3 = (l_all > `SINC3_LOG2_MAX) ? `SINC3_LOG2_MAX : l_all;
		l1 = l_all - l3;
		norm_shift = 7'(l3) * 7'h03 + 7'(l1);
		mask_all = low_mask(l_all);
		mask3 = low_mask(l3);
		hp_shift = 5'(highpass_cutoff_code_in) + 5'h01;
	end

	// ------------------------------------------------------------
	// Per-channel windows and filters
	// ------------------------------------------------------------
	logic [NUM_CHANNELS-1:0]                dump3;
	logic [NUM_CHANNELS-1:0]                dump1;
	logic [NUM_CHANNELS-1:0]                hp_en;
	logic [NUM_CHANNELS-1:0][`RESULT_W-1:0] ch_result;
	logic [NUM_CHANNELS-1:0]                ch_valid;

	genvar g;
	generate
		for (g = 0; g < NUM_CHANNELS; g++)
		begin : g_chan
			logic signed [10:0] phase;
			logic [`WIN_W-1:0]  rel;

			always_comb
			begin
				phase = clip_phase(channel_setup_in[g].channel_phase_offset, l3);
				// Window position relative to the shared counter; power-of-two OSR makes the mask a modulo
				rel = `WIN_W'(15'({1'b0, st.gcnt}) - 15'(phase)) & mask_all;
				dump3[g] = (rel & mask3) == mask3;
				dump1[g] = rel == mask_all;
				hp_en[g] = (highpass_cutoff_code_in != `HP_CODE_OFF)
					&& !channel_setup_in[g].channel_highpass_bypass;
			end

			adc_post_channel u_chan
			(
				.ref_clk_in       (ref_clk_in),
				.rst_n_in         (rst_n_in),
				.mod_valid_in     (mod_valid_in),
				.mod_bit_in       (mod_bit_in[g]),
				.dump3_in         (dump3[g]),
				.dump1_in         (dump1[g]),
				.norm_shift_in    (norm_shift),
				.hp_shift_in      (hp_shift),
				.hp_enable_in     (hp_en[g]),
				.result_out       (ch_result[g]),
				.result_valid_out (ch_valid[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Frame collection and two-entry buffer
	// ------------------------------------------------------------
	// A frame is pushed once every channel has delivered, so the ready strobe
	// follows the channel whose window ends last in the gcnt cycle. The buffer cannot stall the
	// modulator; a frame held back too long is overwritten and flagged.
	logic [NUM_CHANNELS-1:0] have_now;
	logic                    pop;
	logic                    push;
	result_t                 frame;

	always_comb
	begin
		next_st = st;
		next_st.strobe = 1'b0;
		next_st.overrun = 1'b0;
		// Select is only mirrored here; the test source
		// itself is analog and shared by all channels
		for (int i = 0; i < NUM_CHANNELS; i++)
			next_st.sel[i] = channel_setup_in[i].channel_input_select;
		if (mod_valid_in)
			next_st.gcnt = (st.gcnt + `WIN_W'h0001) & mask_all;
		have_now = st.have | ch_valid;
		for (int i = 0; i < NUM_CHANNELS; i++)
		begin
			if (ch_valid[i])
				next_st.lat[i] = ch_result[i];
		end
		if ((st.have & ch_valid) != '0)
			next_st.overrun = 1'b1;
		frame.ch0 = next_st.lat[0];
		frame.ch1 = next_st.lat[1];
		pop = result_ready_in && st.vld[0];
		if (pop)
		begin
			next_st.slot[0] = st.slot[1];
			next_st.vld[0] = st.vld[1];
			next_st.vld[1] = 1'b0;
		end
		// Push only when a slot is free after this cycle's pop;
		// otherwise the frame waits and may be overwritten
		push = (&have_now) && !next_st.vld[1];
		next_st.have = push ? '0 : have_now;
		if (push)
		begin
			next_st.strobe = 1'b1;
			if (!next_st.vld[0])
			begin
				next_st.slot[0] = frame;
				next_st.vld[0] = 1'b1;
			end
			else
			begin
				next_st.slot[1] = frame;
				next_st.vld[1] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st <= '0;
		else
			st <= next_st;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign result_data_out = st.slot[0];
	assign result_valid_out = st.vld[0];
	assign result_ready_strobe_out = st.strobe;
	assign result_overrun_out = st.overrun;
	assign channel_input_select_out = st.sel;
endmodule // adc_post_top
`default_nettype wire

/* File: adc_post_map.svh */
// Named constants for the ADC decimation, high-pass and phase block
`ifndef ADC_POST_MAP_SVH
`define ADC_POST_MAP_SVH

`define OSR_CODE_W      4
`define OSR_CODE_MAX    4'h8
`define OSR_LOG2_BASE   5'h06
`define SINC3_LOG2_MAX  5'h0A
`define WIN_W           14
`define PHASE_W         10
`define RESULT_W        24
`define CIC_W           32
`define ACC_W           36
`define WIDE_W          64
`define FULL_SCALE_LOG2 7'h17
`define HP_CODE_W       4
`define HP_CODE_OFF     4'h0
`define SEL_W           2

`endif

/* File: adc_post_pkg.sv */
// Types shared by the ADC post-processing design
`include "adc_post_map.svh"
package adc_post_pkg;

	typedef enum logic [`SEL_W-1:0] {
		SEL_NORMAL   = 2'b00,
		SEL_SHORTED  = 2'b01,
		SEL_TEST_POS = 2'b10,
		SEL_TEST_NEG = 2'b11
	} input_select_t;

	typedef struct packed {
		input_select_t               channel_input_select;
		logic                        channel_highpass_bypass;
		logic signed [`PHASE_W-1:0]  channel_phase_offset;
	} chan_cfg_t;

	typedef struct packed {
		logic signed [`RESULT_W-1:0] ch1;
		logic signed [`RESULT_W-1:0] ch0;
	} result_t;

endpackage

/* File: adc_post_channel.sv */
// One channel: sinc3 decimator, optional sinc1 stage, normaliser and high-pass filter
`timescale 1ns/1ps
`default_nettype none
`include "adc_post_map.svh"
module adc_post_channel
(
	input  wire logic                        ref_clk_in,
	input  wire logic                        rst_n_in,
	input  wire logic                        mod_valid_in,
	input  wire logic                        mod_bit_in,
	input  wire logic                        dump3_in,
	input  wire logic                        dump1_in,
	input  wire logic [6:0]                  norm_shift_in,
	input  wire logic [4:0]                  hp_shift_in,
	input  wire logic                        hp_enable_in,
	output var  logic signed [`RESULT_W-1:0] result_out,
	output var  logic                        result_valid_out
);
	typedef struct packed {
		logic [`CIC_W-1:0]           i1;
		logic [`CIC_W-1:0]           i2;
		logic [`CIC_W-1:0]           i3;
		logic [`CIC_W-1:0]           d1;
		logic [`CIC_W-1:0]           d2;
		logic [`CIC_W-1:0]           d3;
		logic signed [`ACC_W-1:0]    acc;
		logic signed [`CIC_W-1:0]    hp_x1;
		logic signed [`CIC_W-1:0]    hp_y1;
		logic signed [`RESULT_W-1:0] result;
		logic                        valid;
	} chan_state_t;

	chan_state_t st;
	chan_state_t next_st;

	function automatic logic signed [`RESULT_W-1:0] sat24(input logic signed [`WIDE_W-1:0] v);
		logic signed [`WIDE_W-1:0] hi;
		logic signed [`WIDE_W-1:0] lo;
		hi = `WIDE_W'sh7FFFFF;
		lo = -`WIDE_W'sh800000;
		if (v > hi)
			sat24 = 24'sh7FFFFF;
		else if (v < lo)
			sat24 = -24'sh800000;
		else
			sat24 = v[`RESULT_W-1:0];
	endfunction

	logic [`CIC_W-1:0]        x;
	logic [`CIC_W-1:0]        c1;
	logic [`CIC_W-1:0]        c2;
	logic [`CIC_W-1:0]        c3;
	logic signed [`ACC_W-1:0] total;
	logic signed [`WIDE_W-1:0] wide;
	logic signed [`RESULT_W-1:0] norm;
	logic signed [`CIC_W-1:0] hp_x;
	logic signed [`CIC_W-1:0] hp_y;

	always_comb
	begin
		next_st = st;
		next_st.valid = 1'b0;
		x = mod_bit_in ? `CIC_W'h1 : {`CIC_W{1'b1}};
		c1 = '0;
		c2 = '0;
		c3 = '0;
		total = '0;
		wide = '0;
		norm = '0;
		hp_x = '0;
		hp_y = '0;
		if (mod_valid_in)
		begin
			// Integrators wrap on purpose; the combs undo it exactly
			next_st.i1 = st.i1 + x;
			next_st.i2 = st.i2 + next_st.i1;
			next_st.i3 = st.i3 + next_st.i2;
			if (dump3_in)
			begin
				c1 = next_st.i3 - st.d1;
				c2 = c1 - st.d2;
				c3 = c2 - st.d3;
				next_st.d1 = next_st.i3;
				next_st.d2 = c1;
				next_st.d3 = c2;
				total = st.acc + `ACC_W'(signed'(c3));
				next_st.acc = total;
				if (dump1_in)
				begin
					next_st.acc = '0;
					// Scale to 24-bit full scale, then divide by sinc3 ratio cubed times sinc1 ratio
					wide = (`WIDE_W'(total) <<< `FULL_SCALE_LOG2) >>> norm_shift_in;
					norm = sat24(wide);
					hp_x = `CIC_W'(norm);
					// First-order DC block: y = x - x1 + y1 - a*y1
					hp_y = hp_x - st.hp_x1 + st.hp_y1 - (st.hp_y1 >>> hp_shift_in);
					next_st.hp_x1 = hp_x;
					next_st.hp_y1 = hp_enable_in ? hp_y : '0;
					next_st.result = hp_enable_in ? sat24(`WIDE_W'(hp_y)) : norm;
					next_st.valid = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st <= '0;
		else
			st <= next_st;
	end

	assign result_out = st.result;
	assign result_valid_out = st.valid;
endmodule // adc_post_channel
`default_nettype wire

/* File: mod_source.sv */
// Modulator bit-stream source for the post-processing bench
`timescale 1ns/1ps
`default_nettype none
module mod_source
(
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [3:0] mode_in,
	output var  logic       mod_valid_out,
	output var  logic [1:0] mod_bit_out
);
	logic [15:0] lfsr;

	// Restarts at reset so two runs see one stream
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
		if (!rst_n_in)
			lfsr <= 16'hACE1;
		else
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};

	always_comb
	begin
		mod_valid_out = rst_n_in;
		for (int i = 0; i < 2; i++)
			mod_bit_out[i] = mode_in[2*i+1] ? lfsr[7*i] : mode_in[2*i];
	end
endmodule // mod_source
`default_nettype wire

/* File: adc_post_assertions.sv */
// Port checker for the post-processing top
`timescale 1ns/1ps
`default_nettype none
module adc_post_assertions
#(
	parameter int NUM_CHANNELS = 2
)
(
	input wire logic                                       ref_clk_in,
	input wire logic                                       rst_n_in,
	input wire logic                                       mod_valid_in,
	input wire adc_post_pkg::chan_cfg_t [NUM_CHANNELS-1:0] channel_setup_in,
	input wire logic                                       result_ready_in,
	input wire adc_post_pkg::result_t                      result_data_out,
	input wire logic                                       result_valid_out,
	input wire logic                                       result_ready_strobe_out,
	input wire logic                                       result_overrun_out,
	input wire adc_post_pkg::input_select_t [1:0]          channel_input_select_out
);
	import adc_post_pkg::*;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_sel_copy;
		$past(rst_n_in) && $past(rst_n_in, 2) |->
			channel_input_select_out[0] == $past(channel_setup_in[0].channel_input_select)
			&& channel_input_select_out[1] == $past(channel_setup_in[1].channel_input_select);
	endproperty
	a_sel_copy: assert property (p_sel_copy) else $error("select copy wrong");
	property p_strobe_gap;
		result_ready_strobe_out |=> !result_ready_strobe_out [*8];
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("strobes too close");
	property p_strobe_valid;
		result_ready_strobe_out |-> result_valid_out;
	endproperty
	a_strobe_valid: assert property (p_strobe_valid) else $error("strobe without data");
	property p_valid_rise;
		$rose(result_valid_out) |-> result_ready_strobe_out;
	endproperty
	a_valid_rise: assert property (p_valid_rise) else $error("data without strobe");
	property p_strobe_cause;
		result_ready_strobe_out |-> $past(mod_valid_in, 2) || $past(mod_valid_in, 3);
	endproperty
	a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without sample");
	property p_hold;
		result_valid_out && !result_ready_in |=> result_valid_out && $stable(result_data_out);
	endproperty
	a_hold: assert property (p_hold) else $error("head lost while stalled");
	property p_ovr_full;
		result_overrun_out |-> $past(result_valid_out);
	endproperty
	a_ovr_full: assert property (p_ovr_full) else $error("overrun with room");
	property p_ovr_no_strobe;
		result_overrun_out |-> !result_ready_strobe_out;
	endproperty
	a_ovr_no_strobe: assert property (p_ovr_no_strobe) else $error("overrun with push");
endmodule // adc_post_assertions

bind adc_post_top adc_post_assertions #(.NUM_CHANNELS(NUM_CHANNELS)) u_chk
(
	.ref_clk_in, .rst_n_in, .mod_valid_in, .channel_setup_in, .result_ready_in, .result_data_out,
	.result_valid_out, .result_ready_strobe_out, .result_overrun_out, .channel_input_select_out
);
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the post-processing top
`timescale 1ns/1ps
`default_nettype none
module tb;
	import adc_post_pkg::*;
	logic                ref_clk_in = 1'b0;
	logic                rst_n_in = 1'b0;
	logic                mod_valid_in;
	logic [1:0]          mod_bit_in;
	logic [3:0]          osr_code_in = 4'h0;
	logic [3:0]          highpass_cutoff_code_in = 4'h0;
	logic [3:0]          mode = 4'h1;
	chan_cfg_t [1:0]     channel_setup_in = '0;
	logic                result_ready_in = 1'b1;
	result_t             result_data_out;
	logic                result_valid_out;
	logic                result_ready_strobe_out;
	logic                result_overrun_out;
	input_select_t [1:0] channel_input_select_out;
	logic [3:0]          osr_list[3] = '{4'h0, 4'h1, 4'h5};
	int                  err_count = 0;
	int                  n_checks = 0;
	int                  cyc = 0;
	int                  since = 0;
	int                  ovr = 0;
	int                  r;
	int                  n;
	int                  t_log[$];
	int                  ts[$];
	result_t             d_log[$];
	result_t             ds[$];

	adc_post_top #(.NUM_CHANNELS(2)) uut
	(
		.ref_clk_in, .rst_n_in, .mod_valid_in, .mod_bit_in, .osr_code_in, .highpass_cutoff_code_in,
		.channel_setup_in, .result_ready_in, .result_data_out, .result_valid_out,
		.result_ready_strobe_out, .result_overrun_out, .channel_input_select_out
	);
	mod_source src
	(
		.ref_clk_in, .rst_n_in, .mode_in(mode), .mod_valid_out(mod_valid_in), .mod_bit_out(mod_bit_in)
	);

	always #2 ref_clk_in = ~ref_clk_in;

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	always @(posedge ref_clk_in)
	begin
		cyc <= cyc + 1;
		since <= rst_n_in ? since + 1 : 0;
		if (result_overrun_out === 1'b1)
			ovr <= ovr + 1;
		if (result_ready_strobe_out === 1'b1)
		begin
			t_log.push_back(since);
			d_log.push_back(result_data_out);
		end
		if (cyc == 60000)
		begin
			err_count++;
			give_verdict();
		end
	end

	// Fresh reset per setting, so every run starts from window zero
	task automatic run(logic [3:0] osr, logic [3:0] hp, logic [3:0] md, int p1, logic byp1, int frames);
		@(posedge ref_clk_in);
		rst_n_in <= 1'b0;
		osr_code_in <= osr;
		highpass_cutoff_code_in <= hp;
		mode <= md;
		channel_setup_in[1].channel_phase_offset <= p1[9:0];
		channel_setup_in[1].channel_highpass_bypass <= byp1;
		repeat (10) @(posedge ref_clk_in);
		t_log.delete();
		d_log.delete();
		rst_n_in <= 1'b1;
		repeat ((64 << osr) * frames + 4) @(posedge ref_clk_in);
	endtask

	initial
	begin
		void'($urandom(32'h434A));
		run(4'h0, 4'h0, 4'h1, 0, 1'b0, 1);
		for (int s = 0; s < 4; s++)
		begin
			r = $urandom % 4;
			channel_setup_in[0].channel_input_select <= input_select_t'(s);
			channel_setup_in[1].channel_input_select <= input_select_t'(r);
			repeat (3) @(posedge ref_clk_in);
			check("select", {r[1:0], s[1:0]}, channel_input_select_out);
		end
		foreach (osr_list[i])
		begin
			run(osr_list[i], 4'h0, 4'h1, 0, 1'b0, 6);
			check("period", 64 << osr_list[i], t_log[$] - t_log[$-1]);
			check("scale", {24'h800000, 24'h7FFFFF}, d_log[$]);
		end
		run(4'h0, 4'h0, 4'h5, 0, 1'b0, 70);
		check("hp off", {2{24'h7FFFFF}}, d_log[$]);
		run(4'h0, 4'h1, 4'h5, 0, 1'b1, 70);
		check("bypass", 24'h7FFFFF, d_log[$].ch1);
		check("fast decay", 1, $signed(d_log[$].ch0) < 8 && $signed(d_log[$].ch0) > -8);
		run(4'h0, 4'hF, 4'h5, 0, 1'b0, 70);
		check("slow decay", 1, $signed(d_log[$].ch0) > 4194304);
		run(4'h1, 4'h0, 4'hA, 100, 1'b0, 10);
		ts = t_log;
		ds = d_log;
		run(4'h1, 4'h0, 4'hA, 63, 1'b0, 10);
		check("clip high", 1, ts == t_log && ds == d_log);
		run(4'h1, 4'h0, 4'hA, 62, 1'b0, 10);
		check("shift", 1, ts != t_log || ds != d_log);
		run(4'h1, 4'h0, 4'hA, -100, 1'b0, 10);
		ts = t_log;
		ds = d_log;
		run(4'h1, 4'h0, 4'hA, -64, 1'b0, 10);
		check("clip low", 1, ts == t_log && ds == d_log);
		run(4'h0, 4'h0, 4'h1, 0, 1'b0, 2);
		r = ovr;
		result_ready_in <= 1'b0;
		repeat (64 * (5 + $urandom % 3)) @(posedge ref_clk_in);
		check("overrun", 1, ovr > r && result_valid_out === 1'b1);
		result_ready_in <= 1'b1;
		n = 0;
		#1;
		while (result_valid_out === 1'b1 && n < 10)
		begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end
		check("drain", 1, n >= 2 && n < 10);
		give_verdict();
	end
endmodule // tb
`default_nettype wire
